// File: hw/dpt_pkg.sv
// package for the dual pulse-width / interval timer block
// assumes an apb slave at 32-bit data, one aligned word per register
package dpt_pkg;
    localparam int CH_N = 2;
    // register byte offsets: channel c at c*8
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMP    = 8'h04;
    localparam logic [7:0] OFF_STRIDE = 8'h08;
    // control field positions
    localparam int B_PRESCALE = 0;   // [1:0]
    localparam int B_PWM_MODE = 2;
    localparam int B_RUN      = 3;
    localparam int B_FLAG     = 4;
    localparam int B_OUT_EN   = 5;
    localparam int B_IRQ_EN   = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET  = 8'h00;
    localparam logic [7:0] CNT_START  = 8'h00;
    // read-back of a reserved or unmapped word
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cmp;
    } dpt_regs_t;

    typedef struct packed {
        logic       wr_ctrl;
        logic       wr_cmp;
        logic [7:0] wdata;
        logic       rmw;
    } dpt_wr_t;
endpackage

// File: hw/dpt_chan.sv
`timescale 1ns/1ns
// one generator channel: prescaler, 8-bit up-counter, comparator, output
// assumes register writes arrive as one-cycle strobes from the bus slave
module dpt_chan (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             stop_mode,
    input  wire dpt_pkg::dpt_wr_t wr,
    output dpt_pkg::dpt_regs_t    regs,
    output logic [7:0]            count,
    output logic                  wave,
    output logic                  irq
);
    typedef struct packed {
        dpt_pkg::dpt_regs_t r;
        logic [7:0] cmp_act;
        logic [7:0] cnt;
        logic [3:0] pre;
        logic       wave;
    } dpt_chan_st_t;

    dpt_chan_st_t st;
    dpt_chan_st_t next_st;
    logic         tick;
    logic         match;
    logic         set_flag;

    always_comb begin
        next_st  = st;
        // prescale tap: counter clock = mclk / 2^(code+1)
        tick     = (st.pre | ~((4'h2 << st.r.ctrl[dpt_pkg::B_PRESCALE +: 2]) - 4'h1)) == 4'hf;
        match    = st.cnt == st.cmp_act;
        set_flag = 1'b0;
        if (st.r.ctrl[dpt_pkg::B_RUN] && !stop_mode) begin
            next_st.pre = st.pre + 4'h1;
            if (tick) begin
                if (!st.r.ctrl[dpt_pkg::B_PWM_MODE]) begin
                    if (match) begin
                        next_st.cnt     = dpt_pkg::CNT_START;
                        next_st.wave    = ~st.wave;
                        next_st.cmp_act = st.r.cmp;
                        set_flag        = 1'b1;
                    end else begin
                        next_st.cnt = st.cnt + 8'h01;
                    end
                end else begin
                    next_st.cnt = st.cnt + 8'h01;
                    if (match) begin
                        next_st.wave = 1'b0;
                    end
                    if (st.cnt == 8'hff) begin
                        next_st.wave    = 1'b1;
                        next_st.cmp_act = st.r.cmp;
                    end
                end
            end
        end
        if (wr.wr_cmp) begin
            next_st.r.cmp = wr.wdata;
        end
        if (wr.wr_ctrl) begin
            next_st.r.ctrl = wr.wdata & 8'h7f;
            // flag only clears on a written 0; rmw reads it as 1 so keeps it
            next_st.r.ctrl[dpt_pkg::B_FLAG] = st.r.ctrl[dpt_pkg::B_FLAG]
                & (wr.wdata[dpt_pkg::B_FLAG] | wr.rmw);
            if (wr.wdata[dpt_pkg::B_RUN] && !st.r.ctrl[dpt_pkg::B_RUN]) begin
                // start from zero; prescaler is not reset so first period may be short
                next_st.cnt     = dpt_pkg::CNT_START;
                next_st.cmp_act = st.r.cmp;
                next_st.wave    = wr.wdata[dpt_pkg::B_PWM_MODE];
            end
        end
        if (set_flag) begin
            next_st.r.ctrl[dpt_pkg::B_FLAG] = 1'b1; // set wins over clear
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st.r.ctrl  <= dpt_pkg::CTRL_RESET;
            st.r.cmp   <= dpt_pkg::CMP_RESET;
            st.cmp_act <= dpt_pkg::CMP_RESET;
            st.cnt     <= dpt_pkg::CNT_START;
            st.pre     <= 4'h0;
            st.wave    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign regs  = st.r;
    assign count = st.cnt;
    assign wave  = st.wave;
    assign irq   = st.r.ctrl[dpt_pkg::B_IRQ_EN] & st.r.ctrl[dpt_pkg::B_FLAG];

    AST_FLAG_PWM: assert property (@(posedge mclk) disable iff (rst)
        st.r.ctrl[dpt_pkg::B_PWM_MODE] && !st.r.ctrl[dpt_pkg::B_FLAG] && !wr.wr_ctrl
        |=> !st.r.ctrl[dpt_pkg::B_FLAG])
        else $error("flag set in pwm mode");
    AST_TMR_WRAP: assert property (@(posedge mclk) disable iff (rst)
        st.r.ctrl[dpt_pkg::B_RUN] && !stop_mode && tick && match && !wr.wr_ctrl
        && !st.r.ctrl[dpt_pkg::B_PWM_MODE] |=> st.cnt == 8'h00 && st.r.ctrl[dpt_pkg::B_FLAG])
        else $error("timer match did not clear counter and set flag");
    AST_TOGGLE: assert property (@(posedge mclk) disable iff (rst)
        st.r.ctrl[dpt_pkg::B_RUN] && !stop_mode && tick && match && !wr.wr_ctrl
        && !st.r.ctrl[dpt_pkg::B_PWM_MODE] |=> st.wave != $past(st.wave))
        else $error("timer output did not toggle");
    AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (rst)
        stop_mode && !wr.wr_ctrl |=> $stable(st.cnt) && $stable(st.wave))
        else $error("counter moved in stop state");
    AST_PWM_LOW: assert property (@(posedge mclk) disable iff (rst)
        st.r.ctrl[dpt_pkg::B_RUN] && st.r.ctrl[dpt_pkg::B_PWM_MODE] && !stop_mode
        && tick && match && st.cnt != 8'hff && !wr.wr_ctrl |=> !st.wave)
        else $error("pwm output not low after match");
    AST_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        wr.wr_ctrl && !wr.wdata[dpt_pkg::B_FLAG] && !wr.rmw && !set_flag
        |=> !st.r.ctrl[dpt_pkg::B_FLAG])
        else $error("written zero did not clear flag");
endmodule

// File: hw/dpt_top.sv
// What this block does
// - two independent generators, each counter plus comparator
// - mode bit 0 timer, 1 pulse width
// - prescale divides clock by 2,4,8,16
// - run bit starts counter from zero
// - first period may be short by less than one tick
// - timer match sets flag; pwm never does
// - writing zero clears match flag
// - read-modify-write reads flag as one
// - output enable hands pin to generator
// - interrupt when enable and flag set
// - pwm high until match, then low
// - new compare value applies next period
// - stop state freezes counter and output
// - timer match clears counter; interval compare+1
// - timer output toggles on each match
//
// apb slave for two channels; control at ch*8, compare at ch*8+4
// assumes a synchronous mclk-domain apb master and a port mux outside
`timescale 1ns/1ns
module dpt_top #(
    parameter int CH_N = dpt_pkg::CH_N
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              stop_mode,
    input  wire logic              rmw_access,
    input  wire logic [CH_N-1:0]   port_out,
    output logic [CH_N-1:0]        pin_out,
    output logic [CH_N-1:0]        pwm_wave,
    output logic [CH_N-1:0]        match_irq
);
    typedef struct packed {
        logic [31:0] rdata;
    } dpt_top_st_t;

    dpt_top_st_t        st;
    dpt_top_st_t        next_st;
    dpt_pkg::dpt_wr_t   wr     [CH_N];
    dpt_pkg::dpt_regs_t regs   [CH_N];
    logic [7:0]         count  [CH_N];
    logic               access;
    logic               hit;

    assign access  = psel & penable;
    assign pready  = 1'b1;
    assign hit     = paddr[7:3] < 5'(CH_N) && paddr[1:0] == 2'b00;
    assign pslverr = access & ~hit;

    genvar c;
    generate
        for (c = 0; c < CH_N; c++) begin : g_ch
            always_comb begin
                wr[c].wdata   = pwdata[7:0];
                wr[c].rmw     = rmw_access;
                wr[c].wr_ctrl = access && pwrite && paddr == 8'(c * 8) + dpt_pkg::OFF_CTRL;
                wr[c].wr_cmp  = access && pwrite && paddr == 8'(c * 8) + dpt_pkg::OFF_CMP;
            end
            dpt_chan u_chan (
                .mclk      (mclk),
                .rst       (rst),
                .stop_mode (stop_mode),
                .wr        (wr[c]),
                .regs      (regs[c]),
                .count     (count[c]),
                .wave      (pwm_wave[c]),
                .irq       (match_irq[c])
            );
            // pin goes back to the port function when output enable is clear
            assign pin_out[c] = regs[c].ctrl[dpt_pkg::B_OUT_EN] ? pwm_wave[c] : port_out[c];
        end
    endgenerate

    always_comb begin
        next_st = st;
        if (psel && !penable && !pwrite) begin
            next_st.rdata = dpt_pkg::RD_ZERO;
            for (int i = 0; i < CH_N; i++) begin
                if (paddr == 8'(i * 8) + dpt_pkg::OFF_CTRL) begin
                    next_st.rdata = {16'h0000, count[i], regs[i].ctrl};
                end else if (paddr == 8'(i * 8) + dpt_pkg::OFF_CMP) begin
                    next_st.rdata = {24'h000000, regs[i].cmp};
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st.rdata <= dpt_pkg::RD_ZERO;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;

    AST_PIN_MUX: assert property (@(posedge mclk) disable iff (rst)
        pin_out[0] == (regs[0].ctrl[dpt_pkg::B_OUT_EN] ? pwm_wave[0] : port_out[0]))
        else $error("pin mux wrong");
    AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
        match_irq[0] == (regs[0].ctrl[dpt_pkg::B_IRQ_EN] && regs[0].ctrl[dpt_pkg::B_FLAG]))
        else $error("interrupt does not follow flag and enable");
    AST_RESET: assert property (@(posedge mclk)
        $past(rst) |-> regs[0].ctrl == dpt_pkg::CTRL_RESET && match_irq == '0)
        else $error("control not cleared by reset");
endmodule

// File: verification/dpt_indicator.sv
// indicator model on one generator pin: measures the last high and low run
// assumes the pin is sampled on mclk; durations come out in mclk cycles
`timescale 1ns/1ns
module dpt_indicator (
    input  wire logic        mclk,
    input  wire logic        pin,
    output logic [15:0]      high_len = 16'h0000,
    output logic [15:0]      low_len  = 16'h0000
);
    logic        last     = 1'b0;
    logic [15:0] run      = 16'h0000;
    // a run is latched one edge after the level changes
    // plain always: the lengths start at zero, so no always_ff sole-writer rule applies
    always @(posedge mclk) begin
        last <= pin;
        if (pin != last) begin
            run <= 16'h0001;
            if (last)
                high_len <= run;
            else
                low_len <= run;
        end else begin
            run <= run + 16'h0001;
        end
    end
endmodule

// File: verification/dual_pwm_interval_timer_tb.sv
// self-checking bench for the dual pulse-width / interval timer
// assumes dpt_top as the device and one indicator model on each pin
`timescale 1ns/1ns
module dual_pwm_interval_timer_tb;
    logic        mclk       = 1'b0;
    logic        rst        = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic        stop_mode  = 1'b0;
    logic        rmw_access = 1'b0;
    logic [1:0]  port_out   = 2'b10;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pin_out;
    logic [1:0]  pwm_wave;
    logic [1:0]  match_irq;
    logic [15:0] hi [2];
    logic [15:0] lo [2];
    logic [31:0] rd;
    logic        er;
    int          fails       = 0;
    int          checks_done = 0;
    int          cyc         = 0;

    always #2 mclk = ~mclk;

    dpt_top dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .rmw_access(rmw_access), .port_out(port_out),
        .pin_out(pin_out), .pwm_wave(pwm_wave), .match_irq(match_irq));
    dpt_indicator ind0_u (.mclk(mclk), .pin(pin_out[0]), .high_len(hi[0]), .low_len(lo[0]));
    dpt_indicator ind1_u (.mclk(mclk), .pin(pin_out[1]), .high_len(hi[1]), .low_len(lo[1]));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // starts on a fresh edge so back-to-back calls never drive twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic m);
        @(posedge mclk);
        psel       <= 1'b1;
        pwrite     <= w;
        paddr      <= a;
        pwdata     <= {24'h000000, d};
        rmw_access <= m;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel       <= 1'b0;
        penable    <= 1'b0;
        rmw_access <= 1'b0;
    endtask

    task automatic wait_irq;
        for (int i = 0; i < 600 && match_irq[1] !== 1'b1; i++)
            @(posedge mclk);
    endtask

    task automatic t_reset;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, a[7:0], 8'h00, 1'b0);
            chk(rd[15:0], 16'h0000);
        end
        chk({14'h0, pin_out}, {14'h0, port_out});
        chk({14'h0, match_irq}, 16'h0000);
        apb(1'b0, 8'h10, 8'h00, 1'b0);
        chk({15'h0, er}, 16'h0001);
        chk(rd[15:0], 16'h0000);
        $display("reset test done");
    endtask

    task automatic t_pwm;
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, 8'h00, 8'h00, 1'b0);
            apb(1'b1, 8'h04, 8'h3f, 1'b0);
            apb(1'b1, 8'h00, 8'h2c | 8'(p), 1'b0);
            repeat (2 * (256 << (p + 1)) + 8) @(posedge mclk);
            chk(hi[0], 16'(64 << (p + 1)));
            chk(lo[0], 16'(192 << (p + 1)));
            chk({15'h0, pin_out[0]}, {15'h0, pwm_wave[0]});
            apb(1'b0, 8'h00, 8'h00, 1'b0);
            chk({8'h00, rd[7:0]}, {8'h00, 8'h2c | 8'(p)});
        end
        apb(1'b0, 8'h08, 8'h00, 1'b0);
        chk(rd[15:0], 16'h0000);
        $display("pwm test done");
    endtask

    task automatic t_timer;
        apb(1'b1, 8'h08, 8'h00, 1'b0);
        apb(1'b1, 8'h0c, 8'hff, 1'b0);
        apb(1'b1, 8'h08, 8'h68, 1'b0);
        wait_irq();
        chk({15'h0, match_irq[1]}, 16'h0001);
        apb(1'b1, 8'h08, 8'h68, 1'b1);
        apb(1'b0, 8'h08, 8'h00, 1'b0);
        chk({15'h0, rd[4]}, 16'h0001);
        apb(1'b1, 8'h0c, 8'h09, 1'b0);
        apb(1'b1, 8'h08, 8'h68, 1'b0);
        @(negedge mclk);
        chk({15'h0, match_irq[1]}, 16'h0000);
        wait_irq();
        repeat (2) @(posedge mclk);
        chk(hi[1], 16'd512);
        repeat (45) @(posedge mclk);
        chk(lo[1], 16'd20);
        chk(hi[1], 16'd20);
        $display("timer test done");
    endtask

    task automatic t_stop;
        logic [31:0] c0;
        logic [1:0]  w0;
        @(posedge mclk);
        stop_mode <= 1'b1;
        apb(1'b0, 8'h08, 8'h00, 1'b0);
        c0 = rd;
        w0 = pwm_wave;
        repeat (50) @(posedge mclk);
        apb(1'b0, 8'h08, 8'h00, 1'b0);
        chk(rd[15:0], c0[15:0]);
        chk({14'h0, pwm_wave}, {14'h0, w0});
        stop_mode <= 1'b0;
        $display("stop test done");
    endtask

    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ceiling sits well above the roughly 16600 cycles the tests need
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            $display("BAD t=%0t timeout", $time);
            results();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_pwm();
        t_timer();
        t_stop();
        results();
    end
endmodule
